// ==== rtl/emt_pkg.sv ====
// emt_pkg: constants and types of the external memory bus timing block
// assumes one system clock; all timing counts are in system-clock cycles
package emt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register addresses on the special-function bus
   localparam logic [7:0] EMT_ADDR_PAGE   = 8'haa;
   localparam logic [7:0] EMT_ADDR_CONFIG = 8'hab;
   localparam logic [7:0] EMT_ADDR_TIMING = 8'haf;

   // reset values
   localparam logic [4:0] EMT_PAGE_RST   = 5'h00;
   localparam logic [3:0] EMT_CONFIG_RST = 4'h3;
   localparam logic [7:0] EMT_TIMING_RST = 8'hff;

   // field positions
   localparam int EMT_CFG_MODE_LSB = 2;
   localparam int EMT_CFG_ALE_LSB  = 0;
   localparam int EMT_TC_SETUP_LSB = 6;
   localparam int EMT_TC_STRB_LSB  = 2;
   localparam int EMT_TC_HOLD_LSB  = 0;
   localparam int EMT_PAGE_OFF_BIT = 4;

   // fixed overhead of each off-chip move, split before and after
   localparam logic [3:0] EMT_OVH_PRE  = 4'h2;
   localparam logic [3:0] EMT_OVH_POST = 4'h2;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      EMT_MODE_ONCHIP   = 2'h0,
      EMT_MODE_SPLIT    = 2'h1,
      EMT_MODE_SPLIT_BS = 2'h2,
      EMT_MODE_OFFCHIP  = 2'h3
   } emt_mode_e;

   // gray along the normal path
   typedef enum logic [2:0] {
      EMT_IDLE  = 3'h0,
      EMT_PRE   = 3'h1,
      EMT_ALEH  = 3'h3,
      EMT_ALEL  = 3'h2,
      EMT_SETUP = 3'h6,
      EMT_STRB  = 3'h7,
      EMT_HOLD  = 3'h5,
      EMT_POST  = 3'h4
   } emt_state_e;

   typedef struct packed {
      logic        write;
      logic        wide;
      logic [15:0] addr;
      logic [7:0]  ptr;
      logic [7:0]  wdata;
   } emt_req_s;

   typedef struct packed {
      logic [1:0] ale;
      logic [1:0] setup;
      logic [3:0] strb;
      logic [1:0] hold;
   } emt_timing_s;

endpackage

// ==== rtl/emt_bus.sv ====
// emt_bus: register set and off-chip cycle sequencer of the memory interface
// assumes the cpu holds a request until busy rises and that pins are
// combined with port latches outside this block
`timescale 1ns/10ps
module emt_bus
   import emt_pkg::*;
#(
   parameter logic [15:0] ONCHIP_TOP = 16'h1000
) (
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   // special-function register port
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // move requests from the cpu
   input  wire logic        req_valid,
   input  wire emt_req_s    req,
   output logic             busy,
   output logic             done,
   output logic             onchip,
   output logic      [7:0]  rd_data,
   // external bus pins
   output logic      [7:0]  addr_hi_out,
   output logic      [7:0]  addr_hi_oe,
   output logic      [7:0]  ad_out,
   output logic             ad_oe,
   input  wire logic [7:0]  ad_in,
   output logic             ale,
   output logic             rd_n,
   output logic             wr_n
);

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic              rst_meta_q;
   logic              rst_n_q;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [4:0]        page_q;
   logic [3:0]        config_q;
   logic [7:0]        timing_q;
   emt_mode_e         mode;
   emt_timing_s       tc_live;

   assign mode          = emt_mode_e'(config_q[EMT_CFG_MODE_LSB +: 2]);
   assign tc_live.ale   = config_q[EMT_CFG_ALE_LSB +: 2];
   assign tc_live.setup = timing_q[EMT_TC_SETUP_LSB +: 2];
   assign tc_live.strb  = timing_q[EMT_TC_STRB_LSB +: 4];
   assign tc_live.hold  = timing_q[EMT_TC_HOLD_LSB +: 2];

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         page_q   <= EMT_PAGE_RST;
         config_q <= EMT_CONFIG_RST;
         timing_q <= EMT_TIMING_RST;
      end else if (ce && sfr_wr) begin
         case (sfr_addr)
            EMT_ADDR_PAGE:   page_q   <= sfr_wdata[4:0];
            EMT_ADDR_CONFIG: config_q <= sfr_wdata[3:0];
            EMT_ADDR_TIMING: timing_q <= sfr_wdata;
            default:         ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sfr_rdata <= 8'h00;
      end else if (ce && sfr_rd) begin
         case (sfr_addr)
            EMT_ADDR_PAGE:   sfr_rdata <= {3'h0, page_q};
            EMT_ADDR_CONFIG: sfr_rdata <= {4'h0, config_q};
            EMT_ADDR_TIMING: sfr_rdata <= timing_q;
            default:         sfr_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // target decode
   function automatic logic goes_offchip(input emt_mode_e m, input emt_req_s r, input logic [4:0] pg);
      logic off;
      off = 1'b0;
      case (m)
         EMT_MODE_ONCHIP:  off = 1'b0;
         EMT_MODE_OFFCHIP: off = 1'b1;
         default:          off = r.wide ? (r.addr >= ONCHIP_TOP) : pg[EMT_PAGE_OFF_BIT];
      endcase
      return off;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   emt_state_e        state_q;
   emt_state_e        state_d;
   logic [3:0]        cnt_q;
   logic [3:0]        cnt_d;
   emt_timing_s       tc_q;
   emt_req_s          req_q;
   emt_mode_e         mode_q;
   logic              take;
   logic              last;

   assign take = (state_q == EMT_IDLE) && req_valid && goes_offchip(mode, req, page_q);
   assign last = (cnt_q == 4'h0);

   // length of a phase less one; setup and hold may be absent
   function automatic logic [3:0] phase_len(input emt_state_e s, input emt_timing_s t);
      logic [3:0] n;
      n = 4'h0;
      case (s)
         EMT_PRE:   n = EMT_OVH_PRE - 4'h1;
         EMT_ALEH:  n = {2'h0, t.ale};
         EMT_ALEL:  n = {2'h0, t.ale};
         EMT_SETUP: n = {2'h0, t.setup} - 4'h1;
         EMT_STRB:  n = t.strb;
         EMT_HOLD:  n = {2'h0, t.hold} - 4'h1;
         EMT_POST:  n = EMT_OVH_POST - 4'h1;
         default:   n = 4'h0;
      endcase
      return n;
   endfunction

   // zero-length setup and hold phases are skipped outright
   function automatic emt_state_e phase_next(input emt_state_e s, input emt_timing_s t);
      emt_state_e n;
      n = EMT_IDLE;
      case (s)
         EMT_PRE:   n = EMT_ALEH;
         EMT_ALEH:  n = EMT_ALEL;
         EMT_ALEL:  n = (t.setup != 2'h0) ? EMT_SETUP : EMT_STRB;
         EMT_SETUP: n = EMT_STRB;
         EMT_STRB:  n = (t.hold != 2'h0) ? EMT_HOLD : EMT_POST;
         EMT_HOLD:  n = EMT_POST;
         default:   n = EMT_IDLE;
      endcase
      return n;
   endfunction

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         EMT_IDLE: begin
            if (take) begin
               state_d = EMT_PRE;
               cnt_d   = phase_len(EMT_PRE, tc_live);
            end
         end
         default: begin
            if (last) begin
               state_d = phase_next(state_q, tc_q);
               cnt_d   = phase_len(state_d, tc_q);
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= EMT_IDLE;
         cnt_q   <= 4'h0;
      end else if (ce) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // timing is frozen per move so a register write mid-cycle cannot tear it
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tc_q   <= '0;
         req_q  <= '0;
         mode_q <= EMT_MODE_ONCHIP;
      end else if (ce && take) begin
         tc_q   <= tc_live;
         req_q  <= req;
         mode_q <= mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu handshake
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         busy   <= 1'b0;
         done   <= 1'b0;
         onchip <= 1'b0;
      end else if (ce) begin
         busy   <= (state_d != EMT_IDLE);
         done   <= (state_q == EMT_POST) && last;
         onchip <= (state_q == EMT_IDLE) && req_valid && !take;
      end
   end

   // sampled on the final strobe cycle, while the memory still drives
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_data <= 8'h00;
      end else if (ce && (state_q == EMT_STRB) && last && !req_q.write) begin
         rd_data <= ad_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins, registered from the next state
   logic              in_move_d;
   logic              addr_ph_d;
   logic              data_ph_d;
   logic              strb_d;
   emt_req_s          rq_d;
   emt_mode_e         md_d;

   assign rq_d      = take ? req : req_q;
   assign md_d      = take ? mode : mode_q;
   assign in_move_d = (state_d != EMT_IDLE);
   assign addr_ph_d = (state_d == EMT_ALEH) || (state_d == EMT_ALEL);
   assign data_ph_d = (state_d == EMT_SETUP) || (state_d == EMT_STRB) || (state_d == EMT_HOLD);
   assign strb_d    = (state_d == EMT_STRB);

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ale   <= 1'b0;
         rd_n  <= 1'b1;
         wr_n  <= 1'b1;
         ad_oe <= 1'b0;
      end else if (ce) begin
         ale   <= (state_d == EMT_ALEH);
         rd_n  <= !(strb_d && !rq_d.write);
         wr_n  <= !(strb_d && rq_d.write);
         ad_oe <= addr_ph_d || (data_ph_d && rq_d.write);
      end
   end

   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ad_out <= 8'h00;
      end else if (ce) begin
         if (addr_ph_d) begin
            ad_out <= rq_d.wide ? rq_d.addr[7:0] : rq_d.ptr;
         end else if (data_ph_d) begin
            ad_out <= rq_d.wdata;
         end
      end
   end

   // upper lines: wide moves drive all, bank mode page bits 3:0 on the low four, else port latch
   always_ff @(posedge mclk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         addr_hi_out <= 8'h00;
         addr_hi_oe  <= 8'h00;
      end else if (ce) begin
         if (!in_move_d) begin
            addr_hi_oe <= 8'h00;
         end else if (rq_d.wide) begin
            addr_hi_out <= rq_d.addr[15:8];
            addr_hi_oe  <= 8'hff;
         end else if (md_d == EMT_MODE_SPLIT_BS) begin
            addr_hi_out <= {4'h0, page_q[3:0]};
            addr_hi_oe  <= 8'h0f;
         end else begin
            addr_hi_oe  <= 8'h00;
         end
      end
   end

endmodule // emt_bus

// ==== testbench/emt_bus_properties.sv ====
// emt_bus_properties: timing, target and register checks on the ports of emt_bus
// assumes ce held high and timing registers left alone during a move
`timescale 1ns/10ps
module emt_bus_properties
   import emt_pkg::*;
(
   // clock, reset
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       ce,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // move port
   input wire logic       req_valid,
   input wire logic       busy,
   input wire logic       done,
   input wire logic       onchip,
   // pins
   input wire logic [7:0] ad_out,
   input wire logic       ad_oe,
   input wire logic       ale,
   input wire logic       rd_n,
   input wire logic       wr_n
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [7:0] cf_q, tc_q, bc_q;
   logic [4:0] sc_q, ac_q, lc_q;
   wire        strb = !(rd_n && wr_n);
   wire  [7:0] mv_len = 8'h05 + tc_q[7:6] + tc_q[5:2] + tc_q[1:0] + 8'h02 * (cf_q[1:0] + 8'h01);
   ////////////////////////////////////////////////////////////////////////
   // shadow of the timing set, so figures are exact
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cf_q <= {4'h0, EMT_CONFIG_RST};
         tc_q <= EMT_TIMING_RST;
      end else if (ce && sfr_wr) begin
         if (sfr_addr == EMT_ADDR_CONFIG) cf_q <= sfr_wdata;
         if (sfr_addr == EMT_ADDR_TIMING) tc_q <= sfr_wdata;
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sc_q <= 5'h00;
         ac_q <= 5'h00;
         lc_q <= 5'h00;
         bc_q <= 8'h00;
      end else begin
         sc_q <= strb ? sc_q + 5'h01 : 5'h00;
         ac_q <= ale ? ac_q + 5'h01 : 5'h00;
         // cycles since the latch strobe fell; only read at strobe start
         lc_q <= ale ? 5'h00 : lc_q + 5'h01;
         bc_q <= busy ? bc_q + 8'h01 : 8'h00;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   sequence s_ale_end; $fell(ale); endsequence
   sequence s_wr_held; !wr_n && !$past(wr_n); endsequence
   property p_ale_high; s_ale_end |-> ac_q == cf_q[1:0] + 5'h01; endproperty
   a_ale_high: assert property (p_ale_high) else $error("latch pulse width wrong");
   // latch low time plus setup must pass before the strobe starts
   property p_ale_low; $rose(strb) |-> lc_q == cf_q[1:0] + tc_q[7:6] + 5'h01; endproperty
   a_ale_low: assert property (p_ale_low) else $error("latch low or setup time wrong");
   property p_addr_latch; s_ale_end |-> ad_oe && $stable(ad_out); endproperty
   a_addr_latch: assert property (p_addr_latch) else $error("address moved at latch edge");
   property p_strb_len; $fell(strb) |-> sc_q == tc_q[5:2] + 5'h01; endproperty
   a_strb_len: assert property (p_strb_len) else $error("strobe width wrong");
   property p_move_len; $fell(busy) |-> done && bc_q == mv_len; endproperty
   a_move_len: assert property (p_move_len) else $error("move length wrong");
   property p_wr_data; s_wr_held |-> ad_oe && $stable(ad_out); endproperty
   a_wr_data: assert property (p_wr_data) else $error("write data moved in strobe");
   property p_wr_hold; $rose(wr_n) && tc_q[1:0] != 2'h0 |-> ad_oe && $stable(ad_out); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data not held");
   property p_rd_release; !rd_n |-> !ad_oe; endproperty
   a_rd_release: assert property (p_rd_release) else $error("bus driven during read");
   property p_onchip; cf_q[3:2] == 2'h0 && req_valid && !busy |=> onchip && !busy; endproperty
   a_onchip: assert property (p_onchip) else $error("on-chip mode went off-chip");
   property p_cfg_read; ce && sfr_rd && sfr_addr == EMT_ADDR_CONFIG |=> sfr_rdata[7:4] == 4'h0; endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config upper bits not zero");
endmodule // emt_bus_properties

// ==== testbench/emt_mem_model.sv ====
// emt_mem_model: byte memory behind an address latch on the muxed bus
// assumes emt_bus pins; upper address is not decoded
`timescale 1ns/10ps
module emt_mem_model (
   // clock
   input wire logic       mclk,
   // bus from the device
   input wire logic [7:0] ad_out,
   input wire logic       ad_oe,
   input wire logic       ale,
   input wire logic       rd_n,
   input wire logic       wr_n,
   // data back
   output logic     [7:0] ad_in
);
   logic [7:0] mem [256];
   logic [7:0] lat_q;
   logic [7:0] last_q = 8'h00;
   always @(posedge mclk) begin
      if (ale && ad_oe) lat_q <= ad_out;
      if (!wr_n && ad_oe) mem[lat_q] <= ad_out;
      if (!rd_n) last_q <= mem[lat_q];
   end
   // released bus shows the inverse, never a stale copy
   assign ad_in = !rd_n ? mem[lat_q] : ~last_q;
endmodule // emt_mem_model

// ==== testbench/emt_bus_bench.sv ====
// emt_bus_bench: register and move tests of emt_bus against a memory model
// assumes checker and memory model compiled before this file
`timescale 1ns/10ps
module emt_bus_bench;
   import emt_pkg::*;
   logic       mclk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, req_valid = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, hi_q, hoe_q, tc, l, eoe;
   emt_req_s   req = '0;
   wire  [7:0] sfr_rdata, rd_data, addr_hi_out, addr_hi_oe, ad_out, ad_in;
   wire        busy, done, onchip, ad_oe, ale, rd_n, wr_n;
   int         err_count = 0, checked = 0, n;
   always #5 mclk = ~mclk;
   emt_bus i_emt_bus (.mclk, .reset_n, .ce(1'b1), .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .req_valid,
      .req, .busy, .done, .onchip, .rd_data, .addr_hi_out, .addr_hi_oe, .ad_out, .ad_oe, .ad_in, .ale, .rd_n, .wr_n);
   emt_mem_model i_emt_mem_model (.mclk, .ad_out, .ad_oe, .ale, .rd_n, .wr_n, .ad_in);
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
      @(negedge mclk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      cmp(w, e, sfr_rdata);
   endtask
   // done shows len edges after the take edge, when busy drops
   task automatic mv(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] p, input logic [7:0] d,
                     input logic [7:0] len, input logic [7:0] e_oe, input logic [7:0] e_hi);
      @(negedge mclk);
      req = '{w, wd, a, p, d};
      req_valid = 1'b1;
      hoe_q = 8'hxx;
      n = 0;
      while (busy !== 1'b1 && n < 50) begin
         @(posedge mclk);
         #1 n++;
      end
      @(negedge mclk);
      req_valid = 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
         if (ale === 1'b1) begin
            hoe_q = addr_hi_oe;
            hi_q = addr_hi_out;
         end
      end while (done !== 1'b1 && n < 60);
      cmp("move length", len, n[7:0]);
      cmp("addr hi enable", e_oe, hoe_q);
      cmp("addr hi", e_hi & e_oe, hi_q & e_oe);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (12) @(negedge mclk);
      reset_n = 1'b1;
      repeat (3) @(negedge mclk);
      rd(EMT_ADDR_PAGE, 8'h00, "page reset");
      rd(EMT_ADDR_CONFIG, 8'h03, "config reset");
      rd(EMT_ADDR_TIMING, 8'hff, "timing reset");
      wr(8'ha9, 8'h55);
      rd(8'ha9, 8'h00, "unmapped");
      wr(EMT_ADDR_CONFIG, 8'hf0);
      rd(EMT_ADDR_CONFIG, 8'h00, "config upper");
      @(negedge mclk);
      req = '{1'b0, 1'b1, 16'hf000, 8'h00, 8'h00};
      req_valid = 1'b1;
      @(posedge mclk);
      #1 cmp("onchip", 8'h01, {6'h00, busy, onchip});
      @(negedge mclk);
      req_valid = 1'b0;
      for (int i = 0; i < 4; i++) begin
         tc = 8'(8'h55 * i);
         l = 8'h05 + tc[7:6] + tc[5:2] + tc[1:0] + 8'(2 * (i + 1));
         wr(EMT_ADDR_TIMING, tc);
         wr(EMT_ADDR_CONFIG, 8'(8'hf0 | ((i % 3 + 1) << 2) | i));
         mv(1'b1, 1'b1, 16'h1200 + 16'(i), 8'h00, 8'hc0 + 8'(i), l, 8'hff, 8'h12);
         mv(1'b0, 1'b1, 16'h1200 + 16'(i), 8'h00, 8'h00, l, 8'hff, 8'h12);
         cmp("wide data", 8'hc0 + 8'(i), rd_data);
      end
      wr(EMT_ADDR_PAGE, 8'hf3);
      rd(EMT_ADDR_PAGE, 8'h13, "page upper");
      wr(EMT_ADDR_TIMING, 8'h00);
      for (int m = 1; m < 4; m++) begin
         wr(EMT_ADDR_CONFIG, 8'(m << 2));
         eoe = (m == 2) ? 8'h0f : 8'h00;
         mv(1'b1, 1'b0, 16'h0000, 8'h40 + 8'(m), 8'h30 + 8'(m), 8'h07, eoe, 8'h03);
         mv(1'b0, 1'b0, 16'h0000, 8'h40 + 8'(m), 8'h00, 8'h07, eoe, 8'h03);
         cmp("narrow data", 8'h30 + 8'(m), rd_data);
      end
      end_of_test();
   end
endmodule // emt_bus_bench
bind emt_bus emt_bus_properties i_emt_bus_properties (.mclk, .reset_n, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
   .sfr_rdata, .req_valid, .busy, .done, .onchip, .ad_out, .ad_oe, .ale, .rd_n, .wr_n);
